// *** hdl/adp_pkg.sv ***
// adp_pkg: types and constants for one AXI4 slave port of the DRAM port block
// assumes: compiled before every design file that imports it
`default_nettype none
package adp_pkg;
  localparam int unsigned ADDR_W     = 33;
  localparam int unsigned DATA_W     = 512;
  localparam int unsigned STRB_W     = DATA_W / 8;
  localparam int unsigned ID_W       = 6;
  localparam int unsigned LEN_W      = 8;
  localparam int unsigned SIZE_W     = 3;
  localparam int unsigned CACHE_W    = 4;
  localparam int unsigned WORD_LSB   = 6;   // 64-byte data word
  localparam int unsigned MEM_DEPTH  = 16;
  localparam int unsigned MEM_IDX_W  = 4;
  localparam int unsigned WFIFO_DEPTH = 16;

  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 33'h1;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [LEN_W-1:0]   len;
    logic [SIZE_W-1:0]  size;
    logic [1:0]         burst;
    logic [ID_W-1:0]    id;
    logic               lock;
    logic               qos;
    logic               auto_precharge_req;
  } adp_ar_type;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [LEN_W-1:0]   len;
    logic [SIZE_W-1:0]  size;
    logic [1:0]         burst;
    logic [ID_W-1:0]    id;
    logic               lock;
    logic               qos;
    logic               auto_precharge_req;
    logic [CACHE_W-1:0] cache;
    logic               full_strobe_hint;
    logic               coherent_bufferable_sel;
  } adp_aw_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic              last;
  } adp_w_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ID_W-1:0]   id;
    logic [1:0]        resp;
    logic              last;
  } adp_r_type;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0]      resp;
  } adp_b_type;

  // sideband of the commands in flight, handed to the dram scheduler
  typedef struct packed {
    logic               rd_auto_precharge_req;
    logic               rd_qos;
    logic               rd_lock;
    logic               wr_auto_precharge_req;
    logic               wr_qos;
    logic               wr_lock;
    logic [CACHE_W-1:0] wr_cache;
    logic               wr_coherent_bufferable_sel;
  } adp_hint_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_DATA = 2'h1,
    WR_RESP = 2'h2
  } adp_wr_state_type;

  // address of the beat after addr, for incrementing and wrapping bursts
  function automatic logic [ADDR_W-1:0] next_beat_addr(
    input logic [ADDR_W-1:0] addr,
    input logic [1:0]        burst,
    input logic [SIZE_W-1:0] size,
    input logic [LEN_W-1:0]  len
  );
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] span;
    logic [ADDR_W-1:0] aligned;
    logic [ADDR_W-1:0] sum;
    step    = ADDR_ONE << size;
    span    = ({25'h0, len} + ADDR_ONE) << size;
    aligned = addr & ~(step - ADDR_ONE);
    sum     = aligned + step;
    if (burst == BURST_WRAP) begin
      next_beat_addr = (addr & ~(span - ADDR_ONE)) | (sum & (span - ADDR_ONE));
    end else begin
      next_beat_addr = sum;
    end
  endfunction : next_beat_addr
endpackage : adp_pkg
`default_nettype wire

// *** hdl/adp_port.sv ***
// adp_port: one AXI4 slave port of the DRAM port block, with its write-data fifo
// assumes: one instance per port (index 0 and 1), each on the master's clock;
// the backing store is a small flip-flop array standing in for the dram path
//
// Behaviour
// - two independent ports 0 and 1, each with own clock and sync low reset.
// - 512-bit write data with 64 byte strobes, one per byte lane.
// - read beats carry 512-bit data, 6-bit id, 2-bit response, last flag.
// - one write response per burst with id and status, held until ready.
// - incrementing and wrapping bursts; beat address from burst type and size.
// - address ready only when a new address and control can be taken.
// - read and write addresses carry qos, lock and auto-precharge request.
// - write address carries 4-bit memory type and coherent-bufferable select.
`default_nettype none

// =====================================================================
// write data fifo
module adp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);
  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_q != FULL_COUNT);
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = store_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      store_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule : adp_fifo

// =====================================================================
// port slave
module adp_port #(
  parameter int unsigned PORT_INDEX = 0
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire adp_pkg::adp_aw_type aw_in,
  input  wire logic               aw_valid_in,
  output logic                    aw_ready_out,
  input  wire adp_pkg::adp_w_type w_in,
  input  wire logic               w_valid_in,
  output logic                    w_ready_out,
  output adp_pkg::adp_b_type      b_out,
  output logic                    b_valid_out,
  input  wire logic               b_ready_in,
  input  wire adp_pkg::adp_ar_type ar_in,
  input  wire logic               ar_valid_in,
  output logic                    ar_ready_out,
  output adp_pkg::adp_r_type      r_out,
  output logic                    r_valid_out,
  input  wire logic               r_ready_in,
  output adp_pkg::adp_hint_type   hint_out
);
  import adp_pkg::*;

  logic [DATA_W-1:0]    mem_q [MEM_DEPTH];
  adp_wr_state_type     wr_state_q;
  adp_aw_type           aw_q;
  logic [1:0]           wr_resp_q;
  adp_w_type            wf_data;
  logic                 wf_valid;
  logic                 wf_ready;
  logic                 wr_beat;
  logic [STRB_W-1:0]    wr_strb;
  logic [MEM_IDX_W-1:0] wr_idx;
  adp_ar_type           ar_q;
  logic                 rd_busy_q;
  logic [ADDR_W-1:0]    rd_next;
  logic                 ar_take;
  logic                 r_take;
  logic [LEN_W-1:0]     rd_left_q;

  function automatic logic [MEM_IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[WORD_LSB +: MEM_IDX_W];
  endfunction : word_index

  function automatic logic burst_ok(input logic [1:0] b);
    burst_ok = (b == BURST_INCR) || (b == BURST_WRAP);
  endfunction : burst_ok

  // =====================================================================
  // write path
  // beats are buffered so the master can run ahead of the address phase
  adp_fifo #(
    .WIDTH ($bits(adp_w_type)),
    .DEPTH (WFIFO_DEPTH)
  ) u_wfifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_data_in    (w_in),
    .in_valid_in   (w_valid_in),
    .in_ready_out  (w_ready_out),
    .out_data_out  (wf_data),
    .out_valid_out (wf_valid),
    .out_ready_in  (wf_ready)
  );

  assign aw_ready_out = (wr_state_q == WR_IDLE);
  assign wf_ready     = (wr_state_q == WR_DATA);
  assign wr_beat      = wf_valid && wf_ready;
  assign wr_idx       = word_index(aw_q.addr);
  // full-strobe hint writes the whole word; valid only up to 16 beats
  assign wr_strb      = aw_q.full_strobe_hint ? '1 : wf_data.strb;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_state_q <= WR_IDLE;
      aw_q       <= '0;
      wr_resp_q  <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_IDLE: begin
          if (aw_valid_in) begin
            aw_q       <= aw_in;
            wr_resp_q  <= burst_ok(aw_in.burst) ? RESP_OKAY : RESP_SLVERR;
            wr_state_q <= WR_DATA;
          end
        end
        WR_DATA: begin
          if (wr_beat) begin
            aw_q.addr <= next_beat_addr(aw_q.addr, aw_q.burst, aw_q.size, aw_q.len);
            if (wf_data.last) begin
              wr_state_q <= WR_RESP;
            end
          end
        end
        WR_RESP: begin
          if (b_ready_in) begin
            wr_state_q <= WR_IDLE;
          end
        end
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // byte-lane merge into the backing word
  always_ff @(posedge clk_in) begin
    if (wr_beat && wr_resp_q == RESP_OKAY) begin
      for (int i = 0; i < STRB_W; i++) begin
        if (wr_strb[i]) begin
          mem_q[wr_idx][i*8 +: 8] <= wf_data.data[i*8 +: 8];
        end
      end
    end
  end

  assign b_valid_out = (wr_state_q == WR_RESP);
  assign b_out.id    = aw_q.id;
  assign b_out.resp  = wr_resp_q;

  // =====================================================================
  // read path
  assign ar_ready_out = !rd_busy_q;
  assign ar_take      = ar_valid_in && ar_ready_out;
  assign r_take       = r_valid_out && r_ready_in;
  assign rd_next      = next_beat_addr(ar_q.addr, ar_q.burst, ar_q.size, ar_q.len);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_busy_q <= 1'b0;
      ar_q      <= '0;
      r_out     <= '0;
    end else if (ar_take) begin
      rd_busy_q  <= 1'b1;
      ar_q       <= ar_in;
      r_out.data <= mem_q[word_index(ar_in.addr)];
      r_out.id   <= ar_in.id;
      r_out.resp <= burst_ok(ar_in.burst) ? RESP_OKAY : RESP_SLVERR;
      r_out.last <= (ar_in.len == '0);
    end else if (r_take) begin
      // payload changes only after a handshake, so it stays stable while stalled
      if (r_out.last) begin
        rd_busy_q <= 1'b0;
      end else begin
        ar_q.addr  <= rd_next;
        r_out.data <= mem_q[word_index(rd_next)];
        // one beat is left after this handshake when the count reads one
        r_out.last <= (rd_left_q == LEN_W'(1));
      end
    end
  end

  // beats left counts down separately so wrap boundaries keep the full length
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_left_q <= '0;
    end else if (ar_take) begin
      rd_left_q <= ar_in.len;
    end else if (r_take && rd_left_q != '0) begin
      rd_left_q <= rd_left_q - 1'b1;
    end
  end

  assign r_valid_out = rd_busy_q;

  // =====================================================================
  // sideband for the scheduler
  assign hint_out.rd_auto_precharge_req      = ar_q.auto_precharge_req;
  assign hint_out.rd_qos                     = ar_q.qos;
  assign hint_out.rd_lock                    = ar_q.lock;
  assign hint_out.wr_auto_precharge_req      = aw_q.auto_precharge_req;
  assign hint_out.wr_qos                     = aw_q.qos;
  assign hint_out.wr_lock                    = aw_q.lock;
  assign hint_out.wr_cache                   = aw_q.cache;
  assign hint_out.wr_coherent_bufferable_sel = aw_q.coherent_bufferable_sel;
endmodule : adp_port
`default_nettype wire

// *** testbench/adp_master_model.sv ***
// adp_master_model: fabric axi4 master for one port, driven by bench tasks
// assumes: one task at a time; inputs change 1 ns after the rising edge
`default_nettype none
module adp_master_model (
  input  wire logic          clk_in,
  output adp_pkg::adp_aw_type aw_out,
  output logic               aw_valid_out,
  input  wire logic          aw_ready_in,
  output adp_pkg::adp_w_type w_out,
  output logic               w_valid_out,
  input  wire logic          w_ready_in,
  input  wire adp_pkg::adp_b_type b_in,
  input  wire logic          b_valid_in,
  output logic               b_ready_out,
  output adp_pkg::adp_ar_type ar_out,
  output logic               ar_valid_out,
  input  wire logic          ar_ready_in,
  input  wire adp_pkg::adp_r_type r_in,
  input  wire logic          r_valid_in,
  output logic               r_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import adp_pkg::*;
  initial begin
    {aw_out, w_out, ar_out} = '0;
    {aw_valid_out, w_valid_out, ar_valid_out, b_ready_out, r_ready_out} = 5'h0;
  end
  // released payloads show the inverse so stale values never pass
  task automatic put_aw(input adp_aw_type a);
    @(posedge clk_in) #1 aw_out = a;
    aw_valid_out = 1'b1;
    do @(posedge clk_in); while (aw_ready_in !== 1'b1);
    #1 aw_out = ~a;
    aw_valid_out = 1'b0;
  endtask : put_aw
  task automatic put_w(input adp_w_type w);
    @(posedge clk_in) #1 w_out = w;
    w_valid_out = 1'b1;
    do @(posedge clk_in); while (w_ready_in !== 1'b1);
    #1 w_out = ~w;
    w_valid_out = 1'b0;
  endtask : put_w
  task automatic put_ar(input adp_ar_type a);
    @(posedge clk_in) #1 ar_out = a;
    ar_valid_out = 1'b1;
    do @(posedge clk_in); while (ar_ready_in !== 1'b1);
    #1 ar_out = ~a;
    ar_valid_out = 1'b0;
  endtask : put_ar
  task automatic get_b(input int d, output adp_b_type b);
    repeat (d) @(posedge clk_in);
    #1 b_ready_out = 1'b1;
    do @(posedge clk_in); while (b_valid_in !== 1'b1);
    b = b_in;
    #1 b_ready_out = 1'b0;
  endtask : get_b
  task automatic get_r(input int d, output adp_r_type r);
    repeat (d) @(posedge clk_in);
    #1 r_ready_out = 1'b1;
    do @(posedge clk_in); while (r_valid_in !== 1'b1);
    r = r_in;
    #1 r_ready_out = 1'b0;
  endtask : get_r
endmodule : adp_master_model
`default_nettype wire

// *** testbench/adp_port_assertions.sv ***
// adp_port_assertions: handshake and ordering checks on one port's pins
// assumes: bound into every adp_port instance, one clock, low sync reset
`default_nettype none
module adp_port_assertions (
  input wire logic               clk_in,
  input wire logic               resetn_in,
  input wire logic               aw_valid_in,
  input wire logic               aw_ready_out,
  input wire adp_pkg::adp_b_type b_out,
  input wire logic               b_valid_out,
  input wire logic               b_ready_in,
  input wire adp_pkg::adp_ar_type ar_in,
  input wire logic               ar_valid_in,
  input wire logic               ar_ready_out,
  input wire adp_pkg::adp_r_type r_out,
  input wire logic               r_valid_out,
  input wire logic               r_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import adp_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // =================================================================
  // write response, address-ready and read data channels
  property p_b_hold;
    b_valid_out && !b_ready_in |=> b_valid_out && $stable(b_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_once;
    b_valid_out && b_ready_in |=> !b_valid_out;
  endproperty
  a_b_once: assert property (p_b_once) else $error("second write response");
  property p_aw_back;
    b_valid_out && b_ready_in |=> aw_ready_out;
  endproperty
  a_aw_back: assert property (p_aw_back) else $error("write address not reopened");
  property p_aw_busy;
    aw_valid_in && aw_ready_out |=> !aw_ready_out;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write address open while busy");
  property p_ar_busy;
    ar_valid_in && ar_ready_out |=> r_valid_out && !ar_ready_out;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read start wrong");
  property p_r_id;
    ar_valid_in && ar_ready_out |=> r_out.id == $past(ar_in.id);
  endproperty
  a_r_id: assert property (p_r_id) else $error("read id wrong");
  property p_r_hold;
    r_valid_out && !r_ready_in |=> r_valid_out && $stable(r_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read beat dropped");
  property p_r_end;
    r_valid_out && r_ready_in && r_out.last |=> !r_valid_out && ar_ready_out;
  endproperty
  a_r_end: assert property (p_r_end) else $error("read not ended after last");
endmodule : adp_port_assertions
bind adp_port adp_port_assertions u_chk (.clk_in, .resetn_in, .aw_valid_in, .aw_ready_out,
  .b_out, .b_valid_out, .b_ready_in, .ar_in, .ar_valid_in, .ar_ready_out, .r_out,
  .r_valid_out, .r_ready_in);
`default_nettype wire

// *** testbench/axi_dram_port_interface_tb.sv ***
// axi_dram_port_interface_tb: bursts through one port against a word model
// assumes: adp_master_model drives all channels; 25 MHz clock
`default_nettype none
module axi_dram_port_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adp_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  adp_aw_type aw;
  adp_w_type  w;
  adp_ar_type ar;
  adp_b_type  b, bq;
  adp_r_type  r, rq;
  adp_hint_type hint;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [DATA_W-1:0] mem [16];
  int n_errors = 0;
  int compares = 0;
  always #20 clk_in = ~clk_in;
  adp_port #(.PORT_INDEX(0)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .aw_in(aw),
    .aw_valid_in(aw_v), .aw_ready_out(aw_r), .w_in(w), .w_valid_in(w_v), .w_ready_out(w_r),
    .b_out(b), .b_valid_out(b_v), .b_ready_in(b_r), .ar_in(ar), .ar_valid_in(ar_v),
    .ar_ready_out(ar_r), .r_out(r), .r_valid_out(r_v), .r_ready_in(r_r), .hint_out(hint));
  adp_master_model u_mst (.clk_in(clk_in), .aw_out(aw), .aw_valid_out(aw_v), .aw_ready_in(aw_r),
    .w_out(w), .w_valid_out(w_v), .w_ready_in(w_r), .b_in(b), .b_valid_in(b_v), .b_ready_out(b_r),
    .ar_out(ar), .ar_valid_out(ar_v), .ar_ready_in(ar_r), .r_in(r), .r_valid_in(r_v),
    .r_ready_out(r_r));
  // =================================================================
  // helpers
  function automatic logic [DATA_W-1:0] pat(input int k);
    pat = {16{32'h5a000000 + k}};
  endfunction : pat
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [32:0] a, logic [1:0] bt, int n, int w0, logic [63:0] s, logic h);
    logic [DATA_W-1:0] d;
    logic ok;
    ok = (bt == BURST_INCR) || (bt == BURST_WRAP);
    for (int i = 0; i < n; i++) begin
      d = pat(w0 + i);
      u_mst.put_w('{d, s, i == n - 1});
      for (int j = 0; j < 64; j++) begin
        if (ok && (s[j] || h)) begin
          mem[4'(a[9:6] + i)][8*j +: 8] = d[8*j +: 8];
        end
      end
    end
    if (n == 16) chk(w_r, 1'b0);
    u_mst.put_aw('{a, 8'(n - 1), 3'h6, bt, 6'(n), 1'b0, 1'b1, 1'b1, 4'h3, h, 1'b1});
    u_mst.get_b(n, bq);
    chk(bq.id, 6'(n));
    chk(bq.resp, ok ? RESP_OKAY : RESP_SLVERR);
  endtask : wr
  task automatic rd(logic [32:0] a, logic [1:0] bt, int n);
    logic [3:0] k, m;
    logic ok;
    ok = (bt == BURST_INCR) || (bt == BURST_WRAP);
    m = 4'(n - 1);
    u_mst.put_ar('{a, 8'(n - 1), 3'h6, bt, 6'h9, 1'b1, 1'b0, 1'b1});
    for (int i = 0; i < n; i++) begin
      u_mst.get_r(i % 2, rq);
      k = 4'(a[9:6] + i);
      if (bt == BURST_WRAP) k = (a[9:6] & ~m) | (k & m);
      if (ok) chk(rq.data, mem[k]);
      chk(rq.id, 6'h9);
      chk(rq.resp, ok ? RESP_OKAY : RESP_SLVERR);
      chk(rq.last, i == n - 1);
    end
  endtask : rd
  // =================================================================
  // scenarios
  task automatic t_reset;
    chk({aw_r, ar_r, w_r, b_v, r_v}, 5'h1c);
    chk(hint, '0);
  endtask : t_reset
  task automatic t_incr;
    wr(33'h0, BURST_INCR, 4, 0, '1, 1'b0);
    chk(hint.wr_cache, 4'h3);
    rd(33'h0, BURST_INCR, 4);
    chk(hint.rd_auto_precharge_req, 1'b1);
    chk(hint, 11'h5c7);
  endtask : t_incr
  task automatic t_wrap;
    rd(33'h80, BURST_WRAP, 4);
  endtask : t_wrap
  task automatic t_strb;
    wr(33'h40, BURST_INCR, 2, 7, 64'h0f, 1'b0);
    rd(33'h40, BURST_INCR, 2);
    wr(33'h40, BURST_INCR, 1, 9, 64'h0, 1'b1);
    rd(33'h40, BURST_INCR, 1);
  endtask : t_strb
  task automatic t_bad;
    wr(33'h0, 2'h0, 1, 3, '1, 1'b0);
    rd(33'h0, 2'h0, 1);
  endtask : t_bad
  task automatic t_fifo;
    wr(33'h0, BURST_INCR, 16, 20, '1, 1'b0);
    rd(33'h0, BURST_INCR, 16);
  endtask : t_fifo
  task automatic finish_test;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk_in);
    #1 t_reset();
    repeat (2) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    t_incr();
    t_wrap();
    t_strb();
    t_bad();
    t_fifo();
    finish_test();
  end
  // whole run is about 150 cycles; this is far beyond it
  initial begin
    #100us;
    n_errors++;
    finish_test();
  end
endmodule : axi_dram_port_interface_tb
`default_nettype wire
